// ==== design/fieldbus_drive_command_interface.sv ====
// Behaviour
// - Up to twelve 16-bit words each direction.
// - Each slot carries its selected drive quantity.
// - Command word drives states; status returned.
// - Fast debug mirrors raw command and status.
// - Fast debug mirrors both raw references.
// - Fast debug mirrors both scaled actual words.
// - Reference is a 16-bit two's-complement word.
// - Reference used only where network selected.
// - Reference scaled by set its type picks.
// - Actual word quantity chosen by type.
// - Actual word scaled by set type picks.
// - Bit 0 high advances to ready-to-operate.
// - Bit 0 low ramps down, then ready-on.
// - Bit 1 low coasts, then switch-on inhibited.
// - Bit 2 low quick stops, then inhibited.
// - Bit 3 with run-enable enables operation.
// - Bit 3 low inhibits operation.
// - Bit 4 low forces ramp output zero.
// - Bit 5 low holds ramp output.
// - Bit 6 high proceeds to operating, if sourced.
// - Bit 6 low forces ramp input zero.
// - Bit 7 rising resets an active fault.
// - Bit 10 low passes only bits 0-2.
`timescale 1ns/1ps
`default_nettype none

module fieldbus_word_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [PTR_W:0]   count_reg;
    logic             push;
    logic             pop;

    assign wr_ready = (count_reg != DEPTH[PTR_W:0]);
    assign rd_valid = (count_reg != '0);
    assign rd_data  = mem[rd_ptr_reg];
    assign push     = wr_valid & wr_ready;
    assign pop      = rd_valid & rd_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data;
        end
    end

    // Pointers wrap naturally, so DEPTH must be a power of two.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
            rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop);
            count_reg  <= count_reg + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end
endmodule

module fieldbus_drive_command_interface #(
    parameter int NUM_SLOTS  = fieldbus_pkg::NUM_SLOTS,
    parameter int FIFO_DEPTH = fieldbus_pkg::FIFO_DEPTH
) (
    input  wire logic                                clk_sys,
    input  wire logic                                sys_rst,
    input  wire fieldbus_pkg::in_word_type           in_word,
    input  wire logic                                in_valid,
    output logic                                     in_ready,
    output logic [NUM_SLOTS*fieldbus_pkg::WORD_W-1:0] out_frame,
    output logic                                     out_valid,
    input  wire logic                                out_ready,
    input  wire fieldbus_pkg::drive_cfg_type         cfg,
    input  wire logic [NUM_SLOTS*fieldbus_pkg::SEL_W-1:0] in_slot_sel,
    input  wire logic [NUM_SLOTS*fieldbus_pkg::SEL_W-1:0] out_slot_sel,
    input  wire logic [fieldbus_pkg::NUM_SCALE*16-1:0]    scale_sets,
    input  wire logic [fieldbus_pkg::NUM_MON*16-1:0]      mon_quantity,
    input  wire logic                                run_enable_in,
    input  wire logic                                fault_active,
    input  wire logic                                stop_done,
    input  wire logic                                warning_in,
    input  wire logic                                at_setpoint_in,
    input  wire logic                                remote_in,
    output fieldbus_pkg::drive_state_type            drive_state,
    output logic [15:0]                              status_word,
    output logic                                     operating,
    output logic                                     ramp_out_zero,
    output logic                                     ramp_hold,
    output logic                                     ramp_in_zero,
    output logic                                     fault_reset,
    output logic [15:0]                              speed_ref,
    output logic [15:0]                              torque_ref,
    output logic [15:0]                              freq_ref,
    output logic [15:0]                              dbg_command,
    output logic [15:0]                              dbg_status,
    output logic [15:0]                              dbg_ref1,
    output logic [15:0]                              dbg_ref2,
    output logic [15:0]                              dbg_act1,
    output logic [15:0]                              dbg_act2
);
    localparam int W = fieldbus_pkg::WORD_W;

    // Signed reference times unsigned scale; the scale is full range at 2^15.
    function automatic logic [15:0] scale_word(input logic [15:0] w, input logic [15:0] s);
        logic signed [32:0] p;
        p = $signed(w) * $signed({1'b0, s});
        return p[fieldbus_pkg::REF_SHIFT +: 16];
    endfunction

    fieldbus_pkg::in_word_type fifo_word;
    fieldbus_pkg::drive_state_type state_reg;
    fieldbus_pkg::drive_state_type state_next;
    logic                     fifo_valid;
    logic                     drain_ready;
    logic                     take;
    logic                     commit;
    logic                     slot_ok;
    logic [1:0]               slot_sel;
    logic [W-1:0]             sh_cmd_reg;
    logic [W-1:0]             sh_ref1_reg;
    logic [W-1:0]             sh_ref2_reg;
    logic [W-1:0]             sh_cmd_next;
    logic [W-1:0]             sh_ref1_next;
    logic [W-1:0]             sh_ref2_next;
    logic [W-1:0]             cmd_reg;
    logic [W-1:0]             cmd_gated;
    logic [W-1:0]             ref1_reg;
    logic [W-1:0]             ref2_reg;
    logic                     first_cmd_reg;
    logic                     reset_rise;
    logic                     run_enable;
    logic                     b0;
    logic                     b1;
    logic                     b2;
    logic                     b3;
    logic [W-1:0]             ref1_scaled;
    logic [W-1:0]             ref2_scaled;
    logic [W-1:0]             act1_word;
    logic [W-1:0]             act2_word;
    logic [W-1:0]             status_next;
    logic [NUM_SLOTS*W-1:0]   frame_next;
    logic                     out_valid_reg;
    logic [NUM_SLOTS*W-1:0]   out_frame_reg;
    logic [15:0]              status_reg;
    fieldbus_word_fifo #(
        .WIDTH ($bits(fieldbus_pkg::in_word_type)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .wr_data  (in_word),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .rd_data  (fifo_word),
        .rd_valid (fifo_valid),
        .rd_ready (drain_ready)
    );

    // A finished frame waits for the master side; draining stops meanwhile so
    // that the next commit never overwrites an unsent answer frame.
    assign drain_ready = ~(out_valid_reg & ~out_ready);
    assign take        = fifo_valid & drain_ready;
    assign commit      = take & fifo_word.last;
    localparam logic [fieldbus_pkg::SLOT_W-1:0] SLOT_W_LIMIT = NUM_SLOTS[fieldbus_pkg::SLOT_W-1:0];
    assign slot_ok     = (fifo_word.slot < SLOT_W_LIMIT);
    assign slot_sel    = in_slot_sel[fifo_word.slot*fieldbus_pkg::SEL_W +: fieldbus_pkg::SEL_W];

    // Words outside the twelve slots still close a frame but carry nothing.
    assign sh_cmd_next  = (take & slot_ok & (slot_sel == fieldbus_pkg::IN_SEL_CMD))
                          ? fifo_word.data : sh_cmd_reg;
    assign sh_ref1_next = (take & slot_ok & (slot_sel == fieldbus_pkg::IN_SEL_REF1))
                          ? fifo_word.data : sh_ref1_reg;
    assign sh_ref2_next = (take & slot_ok & (slot_sel == fieldbus_pkg::IN_SEL_REF2))
                          ? fifo_word.data : sh_ref2_reg;

    // Without remote control only the three stop bits get through.
    assign cmd_gated = sh_cmd_next[fieldbus_pkg::CMD_REMOTE]
        ? sh_cmd_next
        : {cmd_reg[W-1:fieldbus_pkg::CMD_LOCAL_BITS], sh_cmd_next[fieldbus_pkg::CMD_LOCAL_BITS-1:0]};
    assign reset_rise = commit & cmd_gated[fieldbus_pkg::CMD_RESET] & ~cmd_reg[fieldbus_pkg::CMD_RESET]
                        & fault_active & cfg.reset_src_net;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sh_cmd_reg    <= fieldbus_pkg::WORD_RESET;
            sh_ref1_reg   <= fieldbus_pkg::WORD_RESET;
            sh_ref2_reg   <= fieldbus_pkg::WORD_RESET;
            cmd_reg       <= fieldbus_pkg::WORD_RESET;
            ref1_reg      <= fieldbus_pkg::WORD_RESET;
            ref2_reg      <= fieldbus_pkg::WORD_RESET;
            first_cmd_reg <= 1'b0;
        end else begin
            sh_cmd_reg  <= sh_cmd_next;
            sh_ref1_reg <= sh_ref1_next;
            sh_ref2_reg <= sh_ref2_next;
            if (commit) begin
                cmd_reg       <= cmd_gated;
                first_cmd_reg <= 1'b1;
                if (sh_cmd_next[fieldbus_pkg::CMD_REMOTE]) begin
                    ref1_reg <= sh_ref1_next;
                    ref2_reg <= sh_ref2_next;
                end
            end
        end
    end

    assign b0 = cmd_reg[fieldbus_pkg::CMD_RAMP_STOP];
    assign b1 = cmd_reg[fieldbus_pkg::CMD_COAST_STOP];
    assign b2 = cmd_reg[fieldbus_pkg::CMD_QUICK_STOP];
    assign b3 = cmd_reg[fieldbus_pkg::CMD_RUN];
    assign run_enable = cfg.run_en_src_net ? b3 : run_enable_in;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fieldbus_pkg::not_ready_on: if (first_cmd_reg) state_next = fieldbus_pkg::switch_on_inhibited;
            fieldbus_pkg::switch_on_inhibited: if (b1 & b2 & ~b0) state_next = fieldbus_pkg::ready_to_switch_on;
            fieldbus_pkg::ready_to_switch_on: if (b0) state_next = fieldbus_pkg::ready_to_operate;
            fieldbus_pkg::ready_to_operate:
                if (~b0) state_next = fieldbus_pkg::ready_to_switch_on;
                else if (b3 & run_enable) state_next = fieldbus_pkg::operation_enabled;
            fieldbus_pkg::operation_enabled:
                if (~b0) state_next = fieldbus_pkg::ramp_stop_active;
                else if (~b3) state_next = fieldbus_pkg::ready_to_operate;
            fieldbus_pkg::ramp_stop_active: if (stop_done) state_next = fieldbus_pkg::ready_to_switch_on;
            fieldbus_pkg::coast_stop_active,
            fieldbus_pkg::quick_stop_active: if (stop_done) state_next = fieldbus_pkg::switch_on_inhibited;
            fieldbus_pkg::fault_state: if (reset_rise) state_next = fieldbus_pkg::switch_on_inhibited;
            default: state_next = fieldbus_pkg::not_ready_on;
        endcase
        // Stop requests override the normal walk, coast before quick stop.
        if (first_cmd_reg && state_reg != fieldbus_pkg::fault_state
            && state_reg != fieldbus_pkg::not_ready_on) begin
            if (~b1 && state_reg != fieldbus_pkg::switch_on_inhibited
                && state_reg != fieldbus_pkg::coast_stop_active) begin
                state_next = fieldbus_pkg::coast_stop_active;
            end else if (~b2 && b1 && state_reg != fieldbus_pkg::switch_on_inhibited
                && state_reg != fieldbus_pkg::coast_stop_active
                && state_reg != fieldbus_pkg::quick_stop_active) begin
                state_next = fieldbus_pkg::quick_stop_active;
            end
        end
        if (fault_active && state_reg != fieldbus_pkg::fault_state && !reset_rise)
            state_next = fieldbus_pkg::fault_state;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= fieldbus_pkg::not_ready_on;
        end else begin
            state_reg <= state_next;
        end
    end

    assign status_next = {6'h00,
        remote_in, at_setpoint_in, warning_in,
        state_reg == fieldbus_pkg::switch_on_inhibited,
        state_reg != fieldbus_pkg::quick_stop_active,
        state_reg != fieldbus_pkg::coast_stop_active,
        state_reg == fieldbus_pkg::fault_state,
        state_reg == fieldbus_pkg::operation_enabled,
        state_reg == fieldbus_pkg::ready_to_operate || state_reg == fieldbus_pkg::operation_enabled,
        state_reg == fieldbus_pkg::ready_to_switch_on || state_reg == fieldbus_pkg::ready_to_operate
            || state_reg == fieldbus_pkg::operation_enabled};

    assign ref1_scaled = scale_word(ref1_reg, scale_sets[cfg.ref1_type*16 +: 16]);
    assign ref2_scaled = scale_word(ref2_reg, scale_sets[cfg.ref2_type*16 +: 16]);
    assign act1_word   = scale_word(mon_quantity[cfg.act1_type*16 +: 16],
                                    scale_sets[cfg.act1_type*16 +: 16]);
    assign act2_word   = scale_word(mon_quantity[cfg.act2_type*16 +: 16],
                                    scale_sets[cfg.act2_type*16 +: 16]);

    for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_out_slot
        logic [1:0] osel;
        assign osel = out_slot_sel[i*fieldbus_pkg::SEL_W +: fieldbus_pkg::SEL_W];
        assign frame_next[i*W +: W] =
            (osel == fieldbus_pkg::OUT_SEL_STATUS) ? status_reg :
            (osel == fieldbus_pkg::OUT_SEL_ACT1)   ? act1_word :
            (osel == fieldbus_pkg::OUT_SEL_ACT2)   ? act2_word : fieldbus_pkg::WORD_RESET;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_valid_reg <= 1'b0;
            out_frame_reg <= '0;
        end else if (commit) begin
            out_valid_reg <= 1'b1;
            out_frame_reg <= frame_next;
        end else if (out_ready) begin
            out_valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_reg    <= fieldbus_pkg::WORD_RESET;
            ramp_out_zero <= 1'b0;
            ramp_hold     <= 1'b0;
            ramp_in_zero  <= 1'b0;
            operating     <= 1'b0;
            fault_reset   <= 1'b0;
            speed_ref     <= fieldbus_pkg::WORD_RESET;
            torque_ref    <= fieldbus_pkg::WORD_RESET;
            freq_ref      <= fieldbus_pkg::WORD_RESET;
        end else begin
            status_reg    <= status_next;
            ramp_out_zero <= first_cmd_reg & ~cmd_reg[fieldbus_pkg::CMD_RAMP_OUT];
            ramp_hold     <= first_cmd_reg & ~cmd_reg[fieldbus_pkg::CMD_RAMP_HOLD];
            ramp_in_zero  <= first_cmd_reg & cfg.ramp_in_src_net
                             & ~cmd_reg[fieldbus_pkg::CMD_RAMP_IN];
            operating     <= (state_reg == fieldbus_pkg::operation_enabled)
                             & cmd_reg[fieldbus_pkg::CMD_RAMP_OUT]
                             & cmd_reg[fieldbus_pkg::CMD_RAMP_HOLD]
                             & (cmd_reg[fieldbus_pkg::CMD_RAMP_IN] | ~cfg.ramp_in_src_net);
            fault_reset   <= reset_rise;
            speed_ref     <= cfg.speed_src_net  ? ref1_scaled : fieldbus_pkg::WORD_RESET;
            torque_ref    <= cfg.torque_src_net ? ref2_scaled : fieldbus_pkg::WORD_RESET;
            freq_ref      <= cfg.freq_src_net   ? ref1_scaled : fieldbus_pkg::WORD_RESET;
        end
    end

    // Monitor copies read zero while debug is off, so stale traffic never shows.
    always_ff @(posedge clk_sys) begin
        if (sys_rst || !cfg.debug_fast) begin
            dbg_command <= fieldbus_pkg::WORD_RESET;
            dbg_ref1    <= fieldbus_pkg::WORD_RESET;
            dbg_ref2    <= fieldbus_pkg::WORD_RESET;
            dbg_status  <= fieldbus_pkg::WORD_RESET;
            dbg_act1    <= fieldbus_pkg::WORD_RESET;
            dbg_act2    <= fieldbus_pkg::WORD_RESET;
        end else if (commit) begin
            dbg_command <= sh_cmd_next;
            dbg_ref1    <= sh_ref1_next;
            dbg_ref2    <= sh_ref2_next;
            dbg_status  <= status_reg;
            dbg_act1    <= act1_word;
            dbg_act2    <= act2_word;
        end
    end

    assign out_valid   = out_valid_reg;
    assign out_frame   = out_frame_reg;
    assign drive_state = state_reg;
    assign status_word = status_reg;
endmodule

`default_nettype wire

// ==== design/fieldbus_pkg.sv ====
package fieldbus_pkg;

    localparam int NUM_SLOTS  = 12;
    localparam int WORD_W     = 16;
    localparam int SLOT_W     = 4;
    localparam int SEL_W      = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int NUM_SCALE  = 4;
    localparam int NUM_MON    = 4;
    localparam int REF_SHIFT  = 15;

    localparam logic [SEL_W-1:0] IN_SEL_NONE = 2'h0;
    localparam logic [SEL_W-1:0] IN_SEL_CMD  = 2'h1;
    localparam logic [SEL_W-1:0] IN_SEL_REF1 = 2'h2;
    localparam logic [SEL_W-1:0] IN_SEL_REF2 = 2'h3;

    localparam logic [SEL_W-1:0] OUT_SEL_ZERO   = 2'h0;
    localparam logic [SEL_W-1:0] OUT_SEL_STATUS = 2'h1;
    localparam logic [SEL_W-1:0] OUT_SEL_ACT1   = 2'h2;
    localparam logic [SEL_W-1:0] OUT_SEL_ACT2   = 2'h3;

    localparam int CMD_RAMP_STOP  = 0;
    localparam int CMD_COAST_STOP = 1;
    localparam int CMD_QUICK_STOP = 2;
    localparam int CMD_RUN        = 3;
    localparam int CMD_RAMP_OUT   = 4;
    localparam int CMD_RAMP_HOLD  = 5;
    localparam int CMD_RAMP_IN    = 6;
    localparam int CMD_RESET      = 7;
    localparam int CMD_REMOTE     = 10;
    localparam int CMD_LOCAL_BITS = 3;

    localparam int ST_RDY_ON   = 0;
    localparam int ST_RDY_RUN  = 1;
    localparam int ST_RDY_REF  = 2;
    localparam int ST_TRIPPED  = 3;
    localparam int ST_COAST_N  = 4;
    localparam int ST_QUICK_N  = 5;
    localparam int ST_INHIBIT  = 6;
    localparam int ST_WARNING  = 7;
    localparam int ST_AT_SETP  = 8;
    localparam int ST_REMOTE   = 9;

    localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic              last;
        logic [WORD_W-1:0] data;
    } in_word_type;

    typedef struct packed {
        logic             debug_fast;
        logic             run_en_src_net;
        logic             ramp_in_src_net;
        logic             reset_src_net;
        logic             speed_src_net;
        logic             torque_src_net;
        logic             freq_src_net;
        logic [SEL_W-1:0] ref1_type;
        logic [SEL_W-1:0] ref2_type;
        logic [SEL_W-1:0] act1_type;
        logic [SEL_W-1:0] act2_type;
    } drive_cfg_type;

    typedef enum logic [3:0] {
        not_ready_on,
        switch_on_inhibited,
        ready_to_switch_on,
        ready_to_operate,
        operation_enabled,
        ramp_stop_active,
        coast_stop_active,
        quick_stop_active,
        fault_state
    } drive_state_type;

endpackage

// ==== testbench/fieldbus_drive_command_interface_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module fieldbus_drive_command_interface_asserts #(
    parameter int NUM_SLOTS = 12
) (
    input wire logic                          clk_sys,
    input wire logic                          sys_rst,
    input wire logic                          out_valid,
    input wire logic                          out_ready,
    input wire logic [NUM_SLOTS*16-1:0]       out_frame,
    input wire fieldbus_pkg::drive_cfg_type   cfg,
    input wire fieldbus_pkg::drive_state_type drive_state,
    input wire logic [15:0]                   status_word,
    input wire logic                          operating,
    input wire logic                          fault_reset,
    input wire logic [15:0]                   freq_ref
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence s_stall;
        out_valid && !out_ready;
    endsequence
    a_frame_held: assert property (s_stall |=> out_valid && $stable(out_frame)) else $error("frame lost");
    a_reset_state: assert property ($fell(sys_rst) |-> drive_state == fieldbus_pkg::not_ready_on && !operating)
        else $error("bad reset state");
    a_status_rsv: assert property (status_word[15:10] == 6'h00) else $error("status spare set");
    a_op_status: assert property (operating |-> status_word[2]) else $error("operating without enable");
    a_coast_flag: assert property (drive_state == fieldbus_pkg::coast_stop_active |=> !status_word[4])
        else $error("coast flag");
    a_inhibit_flag: assert property (drive_state == fieldbus_pkg::switch_on_inhibited |=> status_word[6])
        else $error("inhibit flag");
    a_fault_flag: assert property (drive_state == fieldbus_pkg::fault_state |=> status_word[3])
        else $error("fault flag");
    a_pulse_once: assert property (fault_reset |=> !fault_reset) else $error("reset pulse long");
    a_freq_off: assert property (!cfg.freq_src_net |-> freq_ref == 16'h0000) else $error("freq used");
endmodule
bind fieldbus_drive_command_interface fieldbus_drive_command_interface_asserts #(.NUM_SLOTS(NUM_SLOTS)) i_asserts (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame),
    .cfg(cfg), .drive_state(drive_state), .status_word(status_word), .operating(operating),
    .fault_reset(fault_reset), .freq_ref(freq_ref));
`default_nettype wire

// ==== testbench/fieldbus_drive_command_interface_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module fieldbus_drive_command_interface_test;
    logic clk_sys = 1'b0, sys_rst = 1'b1, slow = 1'b0, fault_active = 1'b0, stop_done = 1'b1;
    logic in_ready, in_valid, out_valid, out_ready, operating, ramp_out_zero, ramp_hold, ramp_in_zero;
    logic [191:0] out_frame, frame;
    logic [15:0] speed_ref, torque_ref, dbg_command, dbg_ref1, dbg_act1, status_word;
    logic [2:0] flags = 3'h5;
    fieldbus_pkg::in_word_type in_word;
    fieldbus_pkg::drive_state_type drive_state;
    fieldbus_pkg::drive_cfg_type cfg = {7'h7E, 8'h1B};
    int miscompares = 0, tests_run = 0, cycles = 0;
    fieldbus_drive_command_interface i_fieldbus_drive_command_interface (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .in_word(in_word), .in_valid(in_valid), .in_ready(in_ready), .out_frame(out_frame), .out_valid(out_valid),
        .out_ready(out_ready), .cfg(cfg), .in_slot_sel(24'h000039), .out_slot_sel(24'h000039),
        .scale_sets(64'h8000800040008000), .mon_quantity(64'h0ABC123400000000), .run_enable_in(1'b0),
        .fault_active(fault_active), .stop_done(stop_done), .warning_in(flags[0]), .at_setpoint_in(flags[1]),
        .remote_in(flags[2]), .drive_state(drive_state), .status_word(status_word), .operating(operating),
        .ramp_out_zero(ramp_out_zero), .ramp_hold(ramp_hold), .ramp_in_zero(ramp_in_zero), .fault_reset(),
        .speed_ref(speed_ref), .torque_ref(torque_ref), .freq_ref(), .dbg_command(dbg_command), .dbg_status(),
        .dbg_ref1(dbg_ref1), .dbg_ref2(), .dbg_act1(dbg_act1), .dbg_act2());
    fieldbus_master_model i_fieldbus_master_model (.clk_sys(clk_sys), .in_ready(in_ready), .out_valid(out_valid),
        .out_frame(out_frame), .slow(slow), .in_word(in_word), .in_valid(in_valid), .out_ready(out_ready),
        .frame(frame));
    initial forever #10 clk_sys = ~clk_sys;
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        tests_run++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic cmd(input logic [15:0] w);
        i_fieldbus_master_model.send(4'h0, 1'b1, w);
    endtask
    task automatic wait_state(input fieldbus_pkg::drive_state_type s);
        for (int n = 0; n < 50 && drive_state !== s; n++) @(posedge clk_sys);
        check(16'(drive_state), 16'(s));
    endtask
    task automatic t_run;
        cmd(16'h0406);
        cmd(16'h0406);
        wait_state(fieldbus_pkg::ready_to_switch_on);
        cmd(16'h047F);
        wait_state(fieldbus_pkg::operation_enabled);
        repeat (3) @(posedge clk_sys);
        check({12'h000, operating, ramp_out_zero, ramp_hold, ramp_in_zero}, 16'h0008);
        check(status_word, 16'h02B7);
        $display("test run done");
    endtask
    task automatic t_refs;
        i_fieldbus_master_model.send(4'h1, 1'b0, -16'sh4000);
        i_fieldbus_master_model.send(4'h2, 1'b0, 16'h2000);
        cmd(16'h047F);
        repeat (4) @(posedge clk_sys);
        check(speed_ref, 16'hC000);
        check(torque_ref, 16'h1000);
        check(dbg_ref1, 16'hC000);
        check(dbg_command, 16'h047F);
        $display("test refs done");
    endtask
    task automatic t_out;
        slow <= 1'b1;
        cmd(16'h047F);
        repeat (8) @(posedge clk_sys);
        check(frame[31:16], 16'h1234);
        check(frame[47:32], 16'h0ABC);
        check({15'h0000, |frame[191:48]}, 16'h0000);
        check(dbg_act1, 16'h1234);
        slow <= 1'b0;
        $display("test out done");
    endtask
    task automatic t_coast;
        stop_done <= 1'b0;
        cmd(16'h047D);
        wait_state(fieldbus_pkg::coast_stop_active);
        stop_done <= 1'b1;
        wait_state(fieldbus_pkg::switch_on_inhibited);
        $display("test coast done");
    endtask
    task automatic t_fault;
        fault_active <= 1'b1;
        wait_state(fieldbus_pkg::fault_state);
        cmd(16'h0486);
        @(posedge clk_sys);
        fault_active <= 1'b0;
        wait_state(fieldbus_pkg::switch_on_inhibited);
        $display("test fault done");
    endtask
    task automatic finish_test;
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            finish_test;
        end
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_run;
        t_refs;
        t_out;
        t_coast;
        t_fault;
        finish_test;
    end
endmodule
`default_nettype wire

// ==== testbench/fieldbus_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_model (
    input wire logic           clk_sys,
    input wire logic           in_ready,
    input wire logic           out_valid,
    input wire logic [191:0]   out_frame,
    input wire logic           slow,
    output fieldbus_pkg::in_word_type in_word,
    output logic               in_valid,
    output logic               out_ready,
    output logic [191:0]       frame
);
    initial begin
        in_word = '0;
        in_valid = 1'b0;
        out_ready = 1'b1;
        frame = '0;
    end
    // Slow mode takes a frame only every other cycle so the drain path must stall.
    always @(posedge clk_sys) begin
        out_ready <= slow ? ~out_ready : 1'b1;
        if (out_valid && out_ready) frame <= out_frame;
    end
    task automatic send(input logic [3:0] slot, input logic last, input logic [15:0] data);
        @(posedge clk_sys);
        in_word <= '{slot, last, data};
        in_valid <= 1'b1;
        do @(posedge clk_sys); while (in_ready !== 1'b1);
        in_valid <= 1'b0;
        // An idle bus shows the inverse word so no stale value passes as fresh.
        in_word <= ~in_word;
    endtask
endmodule
`default_nettype wire
